// file: rsc_pkg.sv
package rsc_pkg;
  // timing base
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_TIME_MS = 15;
  localparam int SETTLE_CYC = SETTLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BOR_HOLD_US = 500;
  localparam int BOR_HOLD_CYC = BOR_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int INT_HOLD_NS = 64;
  localparam int INT_HOLD_CYC = INT_HOLD_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 22;
  localparam logic [CNT_W-1:0] SETTLE_CYC_V = SETTLE_CYC[CNT_W-1:0];
  localparam logic [CNT_W-1:0] BOR_HOLD_CYC_V = BOR_HOLD_CYC[CNT_W-1:0];
  localparam logic [CNT_W-1:0] INT_HOLD_CYC_V = INT_HOLD_CYC[CNT_W-1:0];

  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CAUSE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_BOR_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SRCR0 = 8'h08;
  localparam logic [ADDR_W-1:0] REG_WD_LOAD = 8'h14;
  localparam logic [ADDR_W-1:0] REG_WD_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] REG_WD_ICR = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_WD_VALUE = 8'h20;
  localparam logic [ADDR_W-1:0] REG_LDO_CTRL = 8'h24;
  localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h28;
  localparam logic [ADDR_W-1:0] REG_ID_BASE = 8'h30;
  localparam int NUM_SRCR = 3;
  localparam int NUM_ID = 7;

  // cause flag positions
  localparam int CAUSE_W = 6;
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BOR = 2;
  localparam int CAUSE_SW = 3;
  localparam int CAUSE_WD = 4;
  localparam int CAUSE_LDO = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h02;
  localparam logic [CAUSE_W-1:0] CAUSE_EXT_ONLY = 6'h01;

  // other reset values and field positions
  localparam int BOR_CTRL_W = 19;
  localparam int STAT_BOR = 0;
  localparam logic [31:0] WD_LOAD_RST = 32'hFFFFFFFF;

  // identity words: values are arbitrary
  localparam logic [NUM_ID-1:0][31:0] ID_VALUES = {
    32'h00000006, 32'h00000005, 32'h00000004, 32'h00000003,
    32'h00000002, 32'h00010001, 32'h00000001};

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_WAIT = 3'b010,
    ST_SETTLE = 3'b100
  } rsc_state_e;

  typedef struct packed {
    logic [15:0] delay;
    logic resample;
    logic resetSel;
    logic enable;
  } rsc_bor_ctrl_s;

  typedef struct packed {
    logic resetEn;
    logic enable;
  } rsc_wd_ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wrData;
    logic wr;
    logic rd;
  } rsc_bus_s;
endpackage : rsc_pkg

// file: rsc_system_reset_controller.sv
// Overview of operation
// - six reset sources all funnel into one internal reset.
// - each reset sets its cause flag; flags survive later reset sequences except a pin reset.
// - an external pin reset after the initial power-up leaves only the external cause flag set.
// - pin reset resets core and peripherals; no test port reset exists here.
// - after pin release internal reset holds for the 15 ms settle count.
// - on release a one-cycle boot strobe makes the core fetch its vectors.
// - power-on waits for pin and power-on inactive, then settle count.
// - power-on indication is honoured only during the initial power-up.
// - brown-out reset is disabled after reset until software enables it.
// - brown-out gives interrupt, or reset only when reset select is set.
// - with resample on, brown-out is rechecked after the programmed delay.
// - after a brown-out reset new detections are blocked for 500 us.
// - three soft reset registers; a 1 bit resets that peripheral.
// - a soft peripheral reset asserts all reset lines of that unit.
// - system reset request resets everything then runs the boot sequence.
// - first watchdog time-out reloads the 32-bit counter and flags interrupt.
// - second time-out with flag set and reset enabled resets the system.
// - pin and power-on use the long settle; internal sources a short hold.
// - seven read-only identity registers are visible to software.
// - enabled regulator loss sets its flag and resets the system.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module rsc_system_reset_controller #(
  parameter logic [rsc_pkg::CNT_W-1:0] SETTLE_CYCLES = rsc_pkg::SETTLE_CYC_V,
  parameter logic [rsc_pkg::CNT_W-1:0] BOR_HOLD_CYCLES = rsc_pkg::BOR_HOLD_CYC_V
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic extRstN,
  input wire logic porActive,
  input wire logic brownoutDetect,
  input wire logic regulatorLoss,
  input wire logic systemResetRequest,
  input wire rsc_pkg::rsc_bus_s busReq,
  output logic [31:0] regRdData_r,
  output logic intRst_r,
  output logic bootStart_r,
  output logic [rsc_pkg::NUM_SRCR*32-1:0] periphRst_r,
  output logic brownoutIntr_r,
  output logic wdIntr_r
);
  import rsc_pkg::*;

  rsc_state_e state_r;
  logic [CNT_W-1:0] seqCnt_r;
  logic longSeq_r;
  logic powerUp_r;
  logic porGate_r;
  logic [CAUSE_W-1:0] cause_r;
  logic [CAUSE_W-1:0] causeSet;
  logic [CAUSE_W-1:0] cause_nxt;
  rsc_bor_ctrl_s borCtrl_r;
  logic borWaiting_r;
  logic [15:0] borWaitCnt_r;
  logic [CNT_W-1:0] borHoldCnt_r;
  logic [31:0] srcr_r [NUM_SRCR];
  logic [31:0] wdLoad_r;
  logic [31:0] wdCnt_r;
  rsc_wd_ctrl_s wdCtrl_r;
  logic ldoEn_r;
  logic [31:0] rdData_nxt;
  logic [CNT_W-1:0] holdLen_r;

  function automatic logic isWrite(input rsc_bus_s b, input logic [ADDR_W-1:0] a);
    return b.wr && (b.addr == a);
  endfunction : isWrite

  function automatic logic [ADDR_W-1:0] wordAddr(input logic [ADDR_W-1:0] base, input int idx);
    return base + ADDR_W'(idx * 4);
  endfunction : wordAddr

  // source qualification
  logic localRst;
  logic porEff;
  logic extHit;
  logic borRaw;
  logic borAct;
  logic borFire;
  logic wdZero;
  logic wdFire;
  logic ldoFire;
  logic anyHit;

  assign localRst = sys_rst | intRst_r;
  assign porEff = porActive & porGate_r;
  assign extHit = ~extRstN;
  assign borRaw = brownoutDetect & borCtrl_r.enable & (borHoldCnt_r == '0);
  assign borAct = borCtrl_r.resample ? (borWaiting_r && borWaitCnt_r == '0 && brownoutDetect) : borRaw;
  assign borFire = borAct & borCtrl_r.resetSel;
  assign wdZero = wdCtrl_r.enable && (wdCnt_r == '0);
  assign wdFire = wdZero & wdIntr_r & wdCtrl_r.resetEn;
  assign ldoFire = regulatorLoss & ldoEn_r;
  assign anyHit = extHit | porEff | borFire | systemResetRequest | wdFire | ldoFire;

  // sequencer: any hit restarts the hold, so a late pin edge always gets a full settle
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r <= ST_WAIT;
      intRst_r <= 1'b1;
      longSeq_r <= 1'b1;
      seqCnt_r <= '0;
      powerUp_r <= 1'b1;
      bootStart_r <= 1'b0;
    end
    else
    begin
      bootStart_r <= 1'b0;
      if (anyHit)
      begin
        state_r <= ST_WAIT;
        intRst_r <= 1'b1;
        longSeq_r <= extHit | porEff | ((state_r != ST_RUN) & longSeq_r);
      end
      else
      begin
        case (state_r)
          ST_WAIT:
          begin
            state_r <= ST_SETTLE;
            seqCnt_r <= longSeq_r ? SETTLE_CYCLES - 1'b1 : INT_HOLD_CYC_V - 1'b1;
          end
          ST_SETTLE:
          begin
            if (seqCnt_r == '0)
            begin
              state_r <= ST_RUN;
              intRst_r <= 1'b0;
              bootStart_r <= 1'b1;
              longSeq_r <= 1'b0;
              powerUp_r <= 1'b0;
            end
            else
            begin
              seqCnt_r <= seqCnt_r - 1'b1;
            end
          end
          ST_RUN:
          begin
            state_r <= ST_RUN;
          end
          default:
          begin
            state_r <= ST_WAIT;
            intRst_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // power-on indication counts only until it is first seen low
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      porGate_r <= 1'b1;
    end
    else if (!porActive)
    begin
      porGate_r <= 1'b0;
    end
  end

  // cause flags: write 1 clears, a new cause in the same cycle wins
  always_comb
  begin
    causeSet = '0;
    causeSet[CAUSE_POR] = porEff;
    causeSet[CAUSE_BOR] = borFire;
    causeSet[CAUSE_SW] = systemResetRequest;
    causeSet[CAUSE_WD] = wdFire;
    causeSet[CAUSE_LDO] = ldoFire;
    cause_nxt = cause_r;
    if (isWrite(busReq, REG_CAUSE))
    begin
      cause_nxt = cause_r & ~busReq.wrData[CAUSE_W-1:0];
    end
    cause_nxt = cause_nxt | causeSet;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cause_r <= CAUSE_RST;
    end
    // a pin still held low by the power-on network belongs to power-up, so power-on stays the cause
    else if (extHit && !powerUp_r)
    begin
      cause_r <= CAUSE_EXT_ONLY;
    end
    else
    begin
      cause_r <= cause_nxt;
    end
  end

  // brown-out control, resample and interrupt flag
  always_ff @(posedge clk_sys)
  begin
    if (localRst)
    begin
      borCtrl_r <= '0;
      borWaiting_r <= 1'b0;
      borWaitCnt_r <= '0;
      brownoutIntr_r <= 1'b0;
    end
    else
    begin
      if (isWrite(busReq, REG_BOR_CTRL))
      begin
        borCtrl_r <= rsc_bor_ctrl_s'(busReq.wrData[BOR_CTRL_W-1:0]);
      end
      if (!borWaiting_r && borRaw && borCtrl_r.resample)
      begin
        borWaiting_r <= 1'b1;
        borWaitCnt_r <= borCtrl_r.delay;
      end
      else if (borWaiting_r)
      begin
        if (borWaitCnt_r == '0)
        begin
          borWaiting_r <= 1'b0;
        end
        else
        begin
          borWaitCnt_r <= borWaitCnt_r - 1'b1;
        end
      end
      if (borAct && !borCtrl_r.resetSel)
      begin
        brownoutIntr_r <= 1'b1;
      end
      else if (isWrite(busReq, REG_INT_STAT) && busReq.wrData[STAT_BOR])
      begin
        brownoutIntr_r <= 1'b0;
      end
    end
  end

  // blocking window survives the internal reset so software sees the first cause
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      borHoldCnt_r <= '0;
    end
    else if (borFire)
    begin
      borHoldCnt_r <= BOR_HOLD_CYCLES;
    end
    else if (borHoldCnt_r != '0)
    begin
      borHoldCnt_r <= borHoldCnt_r - 1'b1;
    end
  end

  // soft peripheral resets; internal reset forces every line
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < NUM_SRCR; i++)
    begin
      if (localRst)
      begin
        srcr_r[i] <= '0;
      end
      else if (isWrite(busReq, wordAddr(REG_SRCR0, i)))
      begin
        srcr_r[i] <= busReq.wrData;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      periphRst_r <= '1;
    end
    else
    begin
      for (int i = 0; i < NUM_SRCR; i++)
      begin
        periphRst_r[i*32 +: 32] <= srcr_r[i] | {32{intRst_r}};
      end
    end
  end

  // watchdog
  always_ff @(posedge clk_sys)
  begin
    if (localRst)
    begin
      wdLoad_r <= WD_LOAD_RST;
      wdCnt_r <= WD_LOAD_RST;
      wdCtrl_r <= '0;
      wdIntr_r <= 1'b0;
    end
    else
    begin
      if (isWrite(busReq, REG_WD_LOAD))
      begin
        wdLoad_r <= busReq.wrData;
        wdCnt_r <= busReq.wrData;
      end
      else if (wdZero)
      begin
        wdCnt_r <= wdLoad_r;
      end
      else if (wdCtrl_r.enable)
      begin
        wdCnt_r <= wdCnt_r - 1'b1;
      end
      if (isWrite(busReq, REG_WD_CTRL))
      begin
        wdCtrl_r <= rsc_wd_ctrl_s'(busReq.wrData[1:0]);
      end
      if (wdZero && !wdIntr_r)
      begin
        wdIntr_r <= 1'b1;
      end
      else if (isWrite(busReq, REG_WD_ICR))
      begin
        wdIntr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (localRst)
    begin
      ldoEn_r <= 1'b0;
    end
    else if (isWrite(busReq, REG_LDO_CTRL))
    begin
      ldoEn_r <= busReq.wrData[0];
    end
  end

  // read path; unmapped addresses read zero
  always_comb
  begin
    rdData_nxt = '0;
    case (busReq.addr)
      REG_CAUSE: rdData_nxt = 32'(cause_r);
      REG_BOR_CTRL: rdData_nxt = 32'(borCtrl_r);
      REG_WD_LOAD: rdData_nxt = wdLoad_r;
      REG_WD_CTRL: rdData_nxt = 32'(wdCtrl_r);
      REG_WD_VALUE: rdData_nxt = wdCnt_r;
      REG_LDO_CTRL: rdData_nxt = 32'(ldoEn_r);
      REG_INT_STAT: rdData_nxt = {30'h0, wdIntr_r, brownoutIntr_r};
      default: rdData_nxt = '0;
    endcase
    for (int i = 0; i < NUM_SRCR; i++)
    begin
      if (busReq.addr == wordAddr(REG_SRCR0, i))
      begin
        rdData_nxt = srcr_r[i];
      end
    end
    for (int i = 0; i < NUM_ID; i++)
    begin
      if (busReq.addr == wordAddr(REG_ID_BASE, i))
      begin
        rdData_nxt = ID_VALUES[i];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      regRdData_r <= '0;
    end
    else if (busReq.rd)
    begin
      regRdData_r <= rdData_nxt;
    end
    else
    begin
      regRdData_r <= '0;
    end
  end

  // helper for checks: cycles spent in the settle state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || state_r != ST_SETTLE)
    begin
      holdLen_r <= '0;
    end
    else
    begin
      holdLen_r <= holdLen_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence sPinRelease;
    !extRstN ##1 extRstN;
  endsequence

  sequence sResampleGone;
    borWaiting_r && borWaitCnt_r == '0 && !brownoutDetect && !intRst_r && !brownoutIntr_r;
  endsequence

  AST_EXT_CAUSE: assert property (!extRstN && !powerUp_r |=> cause_r == CAUSE_EXT_ONLY && intRst_r)
    else $error("pin reset did not leave only the external cause");
  AST_PIN_HOLD: assert property (sPinRelease |-> intRst_r ##1 intRst_r)
    else $error("internal reset released right after pin release");
  AST_SETTLE_LEN: assert property ($fell(intRst_r) && $past(longSeq_r) |-> holdLen_r == SETTLE_CYCLES)
    else $error("settle count length wrong");
  AST_BOOT: assert property ($fell(intRst_r) |-> bootStart_r ##1 !bootStart_r)
    else $error("boot strobe not one cycle at release");
  AST_BOR_OFF: assert property (!borCtrl_r.enable && !borWaiting_r |-> !borAct)
    else $error("brown-out acted while disabled");
  AST_BOR_IRQ: assert property (borAct && !borCtrl_r.resetSel |=> brownoutIntr_r)
    else $error("brown-out without select gave no interrupt");
  AST_BOR_RESAMPLE: assert property (sResampleGone and (extRstN && !porEff && !systemResetRequest)
    and (!wdFire && !ldoFire) |=> !intRst_r && !brownoutIntr_r)
    else $error("brown-out acted though gone at recheck");
  AST_BOR_HOLD: assert property (borFire |=> borHoldCnt_r == BOR_HOLD_CYCLES && !borRaw)
    else $error("brown-out hold window not started");
  AST_SRCR: assert property (isWrite(busReq, REG_SRCR0) && busReq.wrData[0] && !intRst_r
    |=> ##1 periphRst_r[0])
    else $error("soft reset bit did not reset peripheral");
  AST_SW_REQ: assert property (systemResetRequest |=> intRst_r && (cause_r[CAUSE_SW] || cause_r[CAUSE_EXT]))
    else $error("system reset request ignored");
  AST_WD_FIRST: assert property (wdZero && !wdIntr_r && !intRst_r && !isWrite(busReq, REG_WD_LOAD)
    |=> wdIntr_r && wdCnt_r == $past(wdLoad_r))
    else $error("first time-out did not reload and flag");
  AST_WD_SECOND: assert property (wdFire |=> intRst_r ##1 !wdCtrl_r.enable)
    else $error("second time-out did not reset");
  AST_LDO: assert property (ldoFire && extRstN |=> intRst_r && cause_r[CAUSE_LDO])
    else $error("regulator loss did not reset");
endmodule : rsc_system_reset_controller

// file: rsc_board_model.sv
`timescale 1ns/1ps
// board side: power supply with a slow ramp, an rc-extended reset pin with pull-up, and a push button
module rsc_board_model #(
  parameter int POR_CYC = 30,
  parameter int PIN_CYC = 40
) (
  input wire logic clk_sys,
  input wire logic button,
  input wire logic porGlitch,
  output logic extRstN,
  output logic porActive
);
  int cnt_r = 0;
  logic rcHold_r = 1'b1;
  logic porHold_r = 1'b1;

  // rc network outlasts the power-on pulse, so the pin is the later of the two
  always @(posedge clk_sys)
  begin
    if (cnt_r < PIN_CYC)
    begin
      cnt_r <= cnt_r + 1;
    end
    porHold_r <= (cnt_r < POR_CYC - 1);
    rcHold_r <= (cnt_r < PIN_CYC - 1);
  end

  // pull-up takes the pin high whenever nothing holds it down
  assign extRstN = ~(rcHold_r | button);
  assign porActive = porHold_r | porGlitch;
endmodule : rsc_board_model

// file: rsc_system_reset_controller_tb.sv
`timescale 1ns/1ps
module rsc_system_reset_controller_tb;
  import rsc_pkg::*;
  localparam int SETTLE = 20;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic button = 1'b0;
  logic porGlitch = 1'b0;
  logic bo = 1'b0;
  logic regLoss = 1'b0;
  logic swReq = 1'b0;
  rsc_bus_s busReq = '0;
  logic extRstN;
  logic porActive;
  logic [31:0] regRdData_r;
  logic intRst_r;
  logic bootStart_r;
  logic [NUM_SRCR*32-1:0] periphRst_r;
  logic brownoutIntr_r;
  logic wdIntr_r;
  int failCount = 0;
  int checked = 0;

  rsc_board_model board (.clk_sys(clk_sys), .button(button), .porGlitch(porGlitch), .extRstN(extRstN),
    .porActive(porActive));
  rsc_system_reset_controller #(.SETTLE_CYCLES(22'(SETTLE)), .BOR_HOLD_CYCLES(22'(10))) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .extRstN(extRstN), .porActive(porActive), .brownoutDetect(bo),
    .regulatorLoss(regLoss), .systemResetRequest(swReq), .busReq(busReq), .regRdData_r(regRdData_r),
    .intRst_r(intRst_r), .bootStart_r(bootStart_r), .periphRst_r(periphRst_r),
    .brownoutIntr_r(brownoutIntr_r), .wdIntr_r(wdIntr_r));

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask : wr

  task chkReg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    busReq <= '{addr: a, wrData: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1;
    chk32(regRdData_r, exp);
  endtask : chkReg

  // called just after the last edge that saw the source; counts cycles of held reset
  task measure(input int exp);
    int n;
    n = 0;
    while (intRst_r === 1'b1 && n < 200)
    begin
      n++;
      tick;
    end
    chk32(32'(n), 32'(exp));
    chk32({31'h0, bootStart_r}, 32'h1);
    tick;
    chk32({31'h0, bootStart_r}, 32'h0);
  endtask : measure

  task waitFor(input logic v, input int lim);
    int n;
    n = 0;
    while (intRst_r !== v && n < lim)
    begin
      tick;
      n++;
    end
    if (n == lim)
    begin
      failCount++;
      $display("[FAIL] %0t wait on internal reset ran out", $time);
      give_verdict;
    end
  endtask : waitFor

  task noRst(input int c);
    int h;
    h = 0;
    repeat (c)
    begin
      tick;
      if (intRst_r !== 1'b0)
        h++;
    end
    chk32(32'(h), 32'h0);
  endtask : noRst

  task endTest(input string name);
    $display("test %s done", name);
  endtask : endTest

  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    tick;
    chk32({31'h0, intRst_r}, 32'h1);
    for (int i = 0; i < 100 && extRstN !== 1'b1; i++)
      tick;
    measure(1 + SETTLE);
    chkReg(REG_CAUSE, 32'h02);
    for (int i = 0; i < NUM_ID; i++)
      chkReg(REG_ID_BASE + 8'(4 * i), ID_VALUES[i]);
    wr(REG_ID_BASE, 32'hFFFF0000);
    chkReg(REG_ID_BASE, ID_VALUES[0]);
    chkReg(8'h80, 32'h0);
    endTest("power_on");
    @(posedge clk_sys);
    porGlitch <= 1'b1;
    noRst(6);
    @(posedge clk_sys);
    porGlitch <= 1'b0;
    endTest("por_once");
    for (int k = 0; k < NUM_SRCR; k++)
    begin
      wr(REG_SRCR0 + 8'(4 * k), 32'h80000001 << k);
      tick;
      chk32(periphRst_r[k*32+:32], 32'h80000001 << k);
      wr(REG_SRCR0 + 8'(4 * k), 32'h0);
      tick;
      chk32(periphRst_r[k*32+:32], 32'h0);
    end
    endTest("soft_periph");
    @(posedge clk_sys);
    swReq <= 1'b1;
    @(posedge clk_sys);
    swReq <= 1'b0;
    #1;
    measure(1 + 16);
    chkReg(REG_CAUSE, 32'h0A);
    endTest("sys_request");
    @(posedge clk_sys);
    bo <= 1'b1;
    noRst(5);
    chk32({31'h0, brownoutIntr_r}, 32'h0);
    @(posedge clk_sys);
    bo <= 1'b0;
    wr(REG_BOR_CTRL, 32'h1);
    @(posedge clk_sys);
    bo <= 1'b1;
    noRst(4);
    chk32({31'h0, brownoutIntr_r}, 32'h1);
    @(posedge clk_sys);
    bo <= 1'b0;
    // clear the flag and read it back low before the filtered glitch below; the flag is not checked after the glitch
    wr(REG_INT_STAT, 32'h1);
    chkReg(REG_INT_STAT, 32'h0);
    // resample delay of 8 cycles, select and resample on: a 2-cycle glitch must be filtered
    wr(REG_BOR_CTRL, 32'h47);
    @(posedge clk_sys);
    bo <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    bo <= 1'b0;
    noRst(20);
    @(posedge clk_sys);
    bo <= 1'b1;
    waitFor(1'b1, 20);
    @(posedge clk_sys);
    bo <= 1'b0;
    waitFor(1'b0, 60);
    chkReg(REG_CAUSE, 32'h0E);
    endTest("brown_out");
    wr(REG_WD_LOAD, 32'h20);
    wr(REG_WD_CTRL, 32'h3);
    repeat (45) tick;
    chk32({30'h0, wdIntr_r, intRst_r}, 32'h2);
    waitFor(1'b1, 40);
    waitFor(1'b0, 40);
    chkReg(REG_CAUSE, 32'h1E);
    endTest("watchdog");
    @(posedge clk_sys);
    regLoss <= 1'b1;
    noRst(5);
    @(posedge clk_sys);
    regLoss <= 1'b0;
    wr(REG_LDO_CTRL, 32'h1);
    @(posedge clk_sys);
    regLoss <= 1'b1;
    @(posedge clk_sys);
    regLoss <= 1'b0;
    #1;
    waitFor(1'b1, 5);
    waitFor(1'b0, 40);
    chkReg(REG_CAUSE, 32'h3E);
    endTest("regulator");
    @(posedge clk_sys);
    button <= 1'b1;
    repeat (5) tick;
    chk32({31'h0, intRst_r}, 32'h1);
    chk32(periphRst_r[31:0] & periphRst_r[63:32] & periphRst_r[95:64], 32'hFFFFFFFF);
    @(posedge clk_sys);
    button <= 1'b0;
    #1;
    measure(1 + SETTLE);
    chkReg(REG_CAUSE, {26'h0, CAUSE_EXT_ONLY});
    endTest("pin");
    give_verdict;
  end
endmodule : rsc_system_reset_controller_tb
